// [src/bbs_port.sv]
module bbs_port #(
  parameter int unsigned POWER_UP_RECOVERY_NS = 1000000,
  parameter int unsigned TICK_CYC =
    bbs_pkg::SECOND_NS / bbs_pkg::CLK_NS
) (
  input  logic                       clk,
  input  logic                       rst,
  input  logic                       cs_n,
  input  logic                       oe_n,
  input  logic                       we_n,
  input  logic [bbs_pkg::ADDR_W-1:0] address_lines,
  input  logic [bbs_pkg::DATA_W-1:0] data_lines_in,
  output logic [bbs_pkg::DATA_W-1:0] data_lines_out,
  output logic                       data_lines_oe,
  input  logic                       power_fail,
  input  logic                       battery_low_in,
  output logic                       battery_low_flag,
  output logic                       write_protect
);

  localparam int unsigned REC_RAW =
    (POWER_UP_RECOVERY_NS + bbs_pkg::CLK_NS - 1) / bbs_pkg::CLK_NS;
  localparam logic [31:0] REC_CYC = 32'((REC_RAW < 1) ? 1 : REC_RAW);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
  localparam int          AW = bbs_pkg::ADDR_W;
  localparam int          DW = bbs_pkg::DATA_W;

  // power and battery state
  logic [31:0] rec_r, rec_nxt;
  logic        chk_pend_r, chk_pend_nxt;
  logic        batt_r, batt_nxt;
  logic        prot_r, prot_nxt;
  logic        prot;
  logic        clr_batt;

  // one second tick
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic        tick_r, tick_nxt;
  logic        tick_d_r;

  // access state
  bbs_pkg::bbs_acc_e  state_r, state_nxt;
  logic [AW-1:0]      waddr_r, waddr_nxt;
  logic [DW-1:0]      wdata_r, wdata_nxt;
  logic [AW-1:0]      addr_prev_r;
  logic [bbs_pkg::AGE_W-1:0] addr_age_r, addr_age_nxt;
  logic [bbs_pkg::AGE_W-1:0] sel_age_r, sel_age_nxt;
  logic [bbs_pkg::AGE_W-1:0] gate_age_r, gate_age_nxt;
  logic [DW-1:0]      dout_r, dout_nxt;
  logic               oe_r, oe_nxt;
  logic               wr_act, rd_act, rd_valid;
  logic               mem_we, cp_we;

  // storage and read path
  logic [DW-1:0] mem [bbs_pkg::MEM_DEPTH];
  logic [DW-1:0] mem_q_r;
  logic [DW-1:0] copy_q_r;
  logic          sel_clk_r;
  logic [DW-1:0] rdata;

  // clock register copies
  logic [DW-1:0] copy_r   [bbs_pkg::CLK_N];
  logic [DW-1:0] copy_nxt [bbs_pkg::CLK_N];
  logic [DW-1:0] rtc_b    [bbs_pkg::CLK_N];
  logic          halt;
  logic          upd;

  function automatic logic is_clk(input logic [AW-1:0] a);
    return a >= bbs_pkg::CLK_BASE;
  endfunction

  function automatic logic [bbs_pkg::AGE_W-1:0] age_inc(
      input logic [bbs_pkg::AGE_W-1:0] a);
    return (a == {bbs_pkg::AGE_W{1'b1}}) ? a : a + bbs_pkg::AGE_ONE;
  endfunction

  // power-fail deselect, recovery hold-off and battery check
  always_comb begin
    rec_nxt      = rec_r;
    chk_pend_nxt = chk_pend_r;
    batt_nxt     = batt_r;
    if (power_fail) begin
      rec_nxt      = REC_CYC;
      chk_pend_nxt = 1'b1;
    end else if (rec_r != 32'h0000_0000) begin
      rec_nxt = rec_r - 32'h0000_0001;
    end
    if (clr_batt) begin
      batt_nxt = 1'b0;
    end
    // a fresh check wins over a clear in the same cycle
    if (chk_pend_r && !power_fail) begin
      chk_pend_nxt = 1'b0;
      batt_nxt     = battery_low_in;
    end
    prot_nxt = power_fail || (rec_nxt != 32'h0000_0000);
  end

  assign prot = power_fail || (rec_r != 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_r      <= REC_CYC;
      chk_pend_r <= 1'b1;
      batt_r     <= 1'b0;
      prot_r     <= 1'b1;
    end else begin
      rec_r      <= rec_nxt;
      chk_pend_r <= chk_pend_nxt;
      batt_r     <= batt_nxt;
      prot_r     <= prot_nxt;
    end
  end

  // seconds divider; keeps running through power fail on battery
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (tick_cnt_r >= TICK_LAST) begin
      tick_cnt_nxt = 32'h0000_0000;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
      tick_d_r   <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      tick_d_r   <= tick_r;
    end
  end

  bbs_rtc u_rtc (
    .clk   (clk),
    .rst   (rst),
    .tick  (tick_r),
    .sec   (rtc_b[bbs_pkg::SEC_IDX]),
    .min   (rtc_b[bbs_pkg::MIN_IDX]),
    .hour  (rtc_b[bbs_pkg::HOUR_IDX]),
    .day   (rtc_b[bbs_pkg::DAY_IDX]),
    .date  (rtc_b[bbs_pkg::DATE_IDX]),
    .month (rtc_b[bbs_pkg::MONTH_IDX]),
    .year  (rtc_b[bbs_pkg::YEAR_IDX])
  );

  assign rtc_b[bbs_pkg::CTRL_IDX] = bbs_pkg::COPY_RST;

  // pin decode; select and write strobe ignored while protected
  assign wr_act = !prot && !cs_n && !we_n;
  assign rd_act = !prot && !cs_n && we_n;

  // access sequencer; write data is the last sample before the end
  always_comb begin
    state_nxt = state_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    mem_we    = 1'b0;
    cp_we     = 1'b0;
    clr_batt  = 1'b0;
    unique case (state_r)
      bbs_pkg::ACC_IDLE, bbs_pkg::ACC_READ: begin
        if (wr_act) begin
          state_nxt = bbs_pkg::ACC_WRITE;
          waddr_nxt = address_lines;
          wdata_nxt = data_lines_in;
        end else if (rd_act) begin
          state_nxt = bbs_pkg::ACC_READ;
        end else begin
          state_nxt = bbs_pkg::ACC_IDLE;
        end
      end
      bbs_pkg::ACC_WRITE: begin
        if (prot) begin
          // power lost mid-write: the cycle is dropped, nothing stored
          state_nxt = bbs_pkg::ACC_IDLE;
        end else if (wr_act) begin
          wdata_nxt = data_lines_in;
        end else begin
          // first rising edge of select or write strobe ends the write
          state_nxt = rd_act ? bbs_pkg::ACC_READ : bbs_pkg::ACC_IDLE;
          if (batt_r) begin
            clr_batt = 1'b1;
          end else if (is_clk(waddr_r)) begin
            cp_we = 1'b1;
          end else begin
            mem_we = 1'b1;
          end
        end
      end
    endcase
  end

  // access-time ages; each restarts on its own cause
  always_comb begin
    addr_age_nxt = (address_lines != addr_prev_r) ? bbs_pkg::AGE_ZERO
                                                  : age_inc(addr_age_r);
    sel_age_nxt  = cs_n ? bbs_pkg::AGE_ZERO : age_inc(sel_age_r);
    gate_age_nxt = oe_n ? bbs_pkg::AGE_ZERO : age_inc(gate_age_r);
    // old byte stays on the pins until the hold time and all three access times are met
    rd_valid = (addr_age_nxt >= bbs_pkg::HOLD_CYC) &&
               (addr_age_nxt >= bbs_pkg::ADDR_ACC_CYC) &&
               (sel_age_nxt >= bbs_pkg::SEL_ACC_CYC) &&
               (gate_age_nxt >= bbs_pkg::GATE_ACC_CYC);
    dout_nxt = rd_valid ? rdata : dout_r;
    // a low strobe never drives, even against an open read
    oe_nxt = (state_nxt == bbs_pkg::ACC_READ) && !oe_n;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= bbs_pkg::ACC_IDLE;
      waddr_r     <= {AW{1'b0}};
      wdata_r     <= {DW{1'b0}};
      addr_prev_r <= {AW{1'b0}};
      addr_age_r  <= bbs_pkg::AGE_ZERO;
      sel_age_r   <= bbs_pkg::AGE_ZERO;
      gate_age_r  <= bbs_pkg::AGE_ZERO;
      dout_r      <= {DW{1'b0}};
      oe_r        <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      waddr_r     <= waddr_nxt;
      wdata_r     <= wdata_nxt;
      addr_prev_r <= address_lines;
      addr_age_r  <= addr_age_nxt;
      sel_age_r   <= sel_age_nxt;
      gate_age_r  <= gate_age_nxt;
      dout_r      <= dout_nxt;
      oe_r        <= oe_nxt;
    end
  end

  // byte array; synchronous read keeps it in block memory
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[waddr_r] <= wdata_r;
    end
    mem_q_r   <= mem[address_lines];
    copy_q_r  <= copy_r[address_lines[2:0]];
    sel_clk_r <= is_clk(address_lines);
  end

  assign rdata = sel_clk_r ? copy_q_r : mem_q_r;

  // halt is read straight from the stored control byte
  assign halt = copy_r[bbs_pkg::CTRL_IDX][bbs_pkg::HALT_BIT];
  // update is one cycle wide, so a halt write cannot split it
  assign upd  = tick_d_r && !halt;

  // copy loads: all time bytes at once, then any host write on top
  always_comb begin
    for (int i = 0; i < bbs_pkg::CLK_N; i++) begin
      copy_nxt[i] = copy_r[i];
      if (upd && i != int'(bbs_pkg::CTRL_IDX)) begin
        copy_nxt[i] = rtc_b[i];
      end
      if (cp_we && waddr_r[2:0] == 3'(i)) begin
        copy_nxt[i] = wdata_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < bbs_pkg::CLK_N; i++) begin
        copy_r[i] <= bbs_pkg::COPY_RST;
      end
    end else begin
      for (int i = 0; i < bbs_pkg::CLK_N; i++) begin
        copy_r[i] <= copy_nxt[i];
      end
    end
  end

  assign data_lines_out   = dout_r;
  assign data_lines_oe    = oe_r;
  assign battery_low_flag = batt_r;
  assign write_protect    = prot_r;

endmodule

// [src/bbs_pkg.sv]
package bbs_pkg;

  // array geometry
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 32768;

  // clock rate and pin timing figures, in ns
  localparam int CLK_NS              = 40;
  localparam int SECOND_NS           = 1000000000;
  localparam int ADDRESS_ACCESS_NS   = 100; // longest
  localparam int SELECT_ACCESS_NS    = 100; // longest
  localparam int GATE_ACCESS_NS      = 50;  // longest
  localparam int OUTPUT_HOLD_NS      = 10;  // least
  localparam int STROBE_TO_FLOAT_NS  = 50;  // longest

  // longest time rounds down, least time rounds up, never below one
  function automatic int max_cyc(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction

  function automatic int min_cyc(input int ns);
    return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int AGE_W = 3;
  localparam logic [AGE_W-1:0] ADDR_ACC_CYC =
    AGE_W'(max_cyc(ADDRESS_ACCESS_NS));
  localparam logic [AGE_W-1:0] SEL_ACC_CYC =
    AGE_W'(max_cyc(SELECT_ACCESS_NS));
  localparam logic [AGE_W-1:0] GATE_ACC_CYC =
    AGE_W'(max_cyc(GATE_ACCESS_NS));
  localparam logic [AGE_W-1:0] HOLD_CYC =
    AGE_W'(min_cyc(OUTPUT_HOLD_NS));
  localparam logic [AGE_W-1:0] FLOAT_CYC =
    AGE_W'(max_cyc(STROBE_TO_FLOAT_NS));
  localparam logic [AGE_W-1:0] AGE_ZERO = 3'h0;
  localparam logic [AGE_W-1:0] AGE_ONE  = 3'h1;

  // clock register copies in the top eight bytes
  localparam logic [ADDR_W-1:0] CLK_BASE = 15'h7FF8;
  localparam int                CLK_N    = 8;
  localparam logic [2:0] CTRL_IDX  = 3'h0;
  localparam logic [2:0] SEC_IDX   = 3'h1;
  localparam logic [2:0] MIN_IDX   = 3'h2;
  localparam logic [2:0] HOUR_IDX  = 3'h3;
  localparam logic [2:0] DAY_IDX   = 3'h4;
  localparam logic [2:0] DATE_IDX  = 3'h5;
  localparam logic [2:0] MONTH_IDX = 3'h6;
  localparam logic [2:0] YEAR_IDX  = 3'h7;
  localparam int         HALT_BIT  = 6;
  localparam logic [7:0] COPY_RST  = 8'h00;

  // bcd counter limits and reset values
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] DAY_MAX   = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] FEB       = 8'h02;
  localparam logic [7:0] APR       = 8'h04;
  localparam logic [7:0] JUN       = 8'h06;
  localparam logic [7:0] SEP       = 8'h09;
  localparam logic [7:0] NOV       = 8'h11;
  localparam logic [7:0] LEN_28    = 8'h28;
  localparam logic [7:0] LEN_29    = 8'h29;
  localparam logic [7:0] LEN_30    = 8'h30;
  localparam logic [7:0] LEN_31    = 8'h31;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } bbs_acc_e;

endpackage

// [src/bbs_rtc.sv]
// running time counters, bcd, advanced once per tick
module bbs_rtc (
  input  logic       clk,
  input  logic       rst,
  input  logic       tick,
  output logic [7:0] sec,
  output logic [7:0] min,
  output logic [7:0] hour,
  output logic [7:0] day,
  output logic [7:0] date,
  output logic [7:0] month,
  output logic [7:0] year
);

  logic [7:0] sec_r, min_r, hour_r, day_r, date_r, month_r, year_r;
  logic [7:0] sec_nxt, min_nxt, hour_nxt, day_nxt;
  logic [7:0] date_nxt, month_nxt, year_nxt;

  // returns {carry, next}; wraps to low once top is reached
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] top,
                                         input logic [7:0] low);
    if (v >= top) begin
      return {1'b1, low};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // next time; month length follows the bcd year for leap days
  always_comb begin
    logic [8:0] r;
    logic [7:0] mlen;
    logic       leap;
    r         = 9'h000;
    mlen      = bbs_pkg::LEN_31;
    leap      = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6)
                          : (year_r[3:0] == 4'h0 || year_r[3:0] == 4'h4 ||
                             year_r[3:0] == 4'h8);
    unique case (month_r)
      bbs_pkg::FEB: mlen = leap ? bbs_pkg::LEN_29 : bbs_pkg::LEN_28;
      bbs_pkg::APR, bbs_pkg::JUN,
      bbs_pkg::SEP, bbs_pkg::NOV: mlen = bbs_pkg::LEN_30;
      default:      mlen = bbs_pkg::LEN_31;
    endcase
    sec_nxt   = sec_r;
    min_nxt   = min_r;
    hour_nxt  = hour_r;
    day_nxt   = day_r;
    date_nxt  = date_r;
    month_nxt = month_r;
    year_nxt  = year_r;
    if (tick) begin
      r       = bcd_inc(sec_r, bbs_pkg::SEC_MAX, bbs_pkg::BCD_ZERO);
      sec_nxt = r[7:0];
      if (r[8]) begin
        r       = bcd_inc(min_r, bbs_pkg::SEC_MAX, bbs_pkg::BCD_ZERO);
        min_nxt = r[7:0];
        if (r[8]) begin
          r        = bcd_inc(hour_r, bbs_pkg::HOUR_MAX, bbs_pkg::BCD_ZERO);
          hour_nxt = r[7:0];
          if (r[8]) begin
            r        = bcd_inc(day_r, bbs_pkg::DAY_MAX, bbs_pkg::BCD_ONE);
            day_nxt  = r[7:0];
            r        = bcd_inc(date_r, mlen, bbs_pkg::BCD_ONE);
            date_nxt = r[7:0];
            if (r[8]) begin
              r = bcd_inc(month_r, bbs_pkg::MONTH_MAX, bbs_pkg::BCD_ONE);
              month_nxt = r[7:0];
              if (r[8]) begin
                r        = bcd_inc(year_r, bbs_pkg::YEAR_MAX,
                                   bbs_pkg::BCD_ZERO);
                year_nxt = r[7:0];
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_r   <= bbs_pkg::BCD_ZERO;
      min_r   <= bbs_pkg::BCD_ZERO;
      hour_r  <= bbs_pkg::BCD_ZERO;
      day_r   <= bbs_pkg::BCD_ONE;
      date_r  <= bbs_pkg::BCD_ONE;
      month_r <= bbs_pkg::BCD_ONE;
      year_r  <= bbs_pkg::BCD_ZERO;
    end else begin
      sec_r   <= sec_nxt;
      min_r   <= min_nxt;
      hour_r  <= hour_nxt;
      day_r   <= day_nxt;
      date_r  <= date_nxt;
      month_r <= month_nxt;
      year_r  <= year_nxt;
    end
  end

  assign sec   = sec_r;
  assign min   = min_r;
  assign hour  = hour_r;
  assign day   = day_r;
  assign date  = date_r;
  assign month = month_r;
  assign year  = year_r;

endmodule

// [verif/bbs_port_properties.sv]
// pin-level checks on the port, seen from its own ports only
module bbs_port_chk #(
  parameter int unsigned POWER_UP_RECOVERY_NS = 1000000,
  parameter int unsigned TICK_CYC             = 25000000
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [14:0] address_lines,
  input wire logic [7:0]  data_lines_in,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe,
  input wire logic        power_fail,
  input wire logic        battery_low_in,
  input wire logic        battery_low_flag,
  input wire logic        write_protect
);
  localparam int unsigned REC_CYC = POWER_UP_RECOVERY_NS / bbs_pkg::CLK_NS;
  logic [31:0] since_r;
  logic [31:0] since_nxt;

  // edges since power became good; saturates so it never wraps
  always_comb begin
    since_nxt = (since_r == 32'hFFFFFFFF) ? since_r : since_r + 32'h1;
    if (rst || power_fail)
      since_nxt = 32'h0;
  end

  always_ff @(posedge clk) begin
    since_r <= since_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_drive_needs_read: assert property (
    data_lines_oe |-> $past(!cs_n && !oe_n && we_n))
    else $error("data driven without a read select");
  chk_read_drives: assert property (
    (!cs_n && !oe_n && we_n && !write_protect && !power_fail)
    |=> data_lines_oe)
    else $error("read select did not drive data");
  chk_strobe_floats: assert property (
    (data_lines_oe && !we_n) |=> !data_lines_oe)
    else $error("falling strobe left outputs driven");
  chk_joint_fall_float: assert property (
    ($fell(cs_n) && $fell(we_n)) |-> !data_lines_oe ##1 !data_lines_oe)
    else $error("joint select and strobe fall drove data");
  chk_addr_hold_old: assert property (
    (data_lines_oe && !cs_n && !oe_n && we_n && $changed(address_lines))
    |=> $stable(data_lines_out))
    else $error("old byte not held after address change");
  chk_fail_floats: assert property (
    power_fail |=> (write_protect && !data_lines_oe))
    else $error("power fail did not deselect");
  chk_recovery_holds: assert property (
    (since_r < REC_CYC - 1) |-> write_protect)
    else $error("protection ended before recovery");
  chk_recovery_ends: assert property (
    (since_r == REC_CYC + 2) |-> !write_protect)
    else $error("protection outlasted recovery");
  chk_flag_clears: assert property (
    (battery_low_flag && $past(!write_protect) && $past(!cs_n && !we_n)
     && (cs_n || we_n)) |=> !battery_low_flag)
    else $error("battery flag kept after first write");
  chk_flag_source: assert property (
    $rose(battery_low_flag)
    |-> ($past(battery_low_in) || $past(battery_low_in, 2)))
    else $error("battery flag set with good battery");

  cover property ($rose(data_lines_oe));
  cover property ($fell(battery_low_flag));
  cover property ($fell(power_fail));
endmodule

bind bbs_port bbs_port_chk #(
  .POWER_UP_RECOVERY_NS(POWER_UP_RECOVERY_NS),
  .TICK_CYC            (TICK_CYC)
) u_chk (
  .clk(clk), .rst(rst), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
  .address_lines(address_lines), .data_lines_in(data_lines_in),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
  .power_fail(power_fail), .battery_low_in(battery_low_in),
  .battery_low_flag(battery_low_flag), .write_protect(write_protect)
);

// [verif/bbs_host.sv]
// host on the pin bus; every phase changes pins just after an edge
module bbs_host (
  input  wire logic        clk,
  output logic             cs_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [14:0]      address_lines,
  output logic [7:0]       host_data,
  output logic             host_oe,
  input  wire logic [7:0]  bus_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {cs_n, oe_n, we_n} = 3'h7;
    address_lines = 15'h0000;
    host_data = 8'h00;
    host_oe = 1'h0;
  end

  // ctl is {cs_n, oe_n, we_n}; held n edges, then the wire is sampled
  task automatic bus(input logic [2:0] ctl, input logic drv,
                     input logic [14:0] a, input logic [7:0] d,
                     input int n, output logic [7:0] q);
    @(posedge clk);
    #2;
    {cs_n, oe_n, we_n} = ctl;
    address_lines = a;
    host_oe = drv;
    // a released wire must not look like it kept the last byte
    host_data = drv ? d : ~host_data;
    repeat (n) @(posedge clk);
    #1;
    q = bus_data;
  endtask
endmodule

// [verif/test_battery_backed_sram_clock_port.sv]
module test_battery_backed_sram_clock_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK   = 50;
  localparam int REC_NS = 8000;
  localparam int REC    = REC_NS / bbs_pkg::CLK_NS;
  logic        clk            = 1'h0;
  logic        rst            = 1'h1;
  logic        power_fail     = 1'h0;
  logic        battery_low_in = 1'h1;
  logic        cs_n, oe_n, we_n, data_lines_oe, host_oe;
  logic        battery_low_flag, write_protect;
  logic [14:0] address_lines;
  logic [7:0]  data_lines_in, data_lines_out, host_data;
  int          errors     = 0;
  int          n_compared = 0;

  always #20 clk = ~clk;
  // the wire: host while it drives, else device, else host noise
  assign data_lines_in = host_oe ? host_data
                       : (data_lines_oe ? data_lines_out : host_data);

  bbs_port #(.POWER_UP_RECOVERY_NS(REC_NS), .TICK_CYC(TICK)) u_dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .address_lines(address_lines), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .power_fail(power_fail), .battery_low_in(battery_low_in),
    .battery_low_flag(battery_low_flag), .write_protect(write_protect));
  bbs_host u_host (
    .clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .address_lines(address_lines), .host_data(host_data),
    .host_oe(host_oe), .bus_data(data_lines_in));

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.bus(3'h2, 1'h1, a, d, 3, q);
    u_host.bus(3'h7, 1'h1, a, d, 1, q);
  endtask

  task automatic rd(input logic [14:0] a, output logic [7:0] q);
    logic [7:0] z;
    u_host.bus(3'h1, 1'h0, a, 8'h00, 3, q);
    u_host.bus(3'h7, 1'h0, a, 8'h00, 0, z);
  endtask

  // bounded wait for protection to lift; k counts the edges
  task automatic await_ready(output int k);
    k = 0;
    while (write_protect !== 1'h0 && k < REC + 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    #1;
  endtask

  task automatic t_power_up;
    int k;
    await_ready(k);
    chk1(battery_low_flag, 1'h1);
    chk1(k >= REC - 2, 1'h1);
    chk1(write_protect, 1'h0);
    battery_low_in = 1'h0;
    $display("power_up done");
  endtask

  task automatic t_first_write;
    logic [7:0] q;
    wr(15'h0010, 8'hA5);
    chk1(battery_low_flag, 1'h0);
    rd(15'h0010, q);
    chk1(q !== 8'hA5, 1'h1);
    wr(15'h0010, 8'h5A);
    rd(15'h0010, q);
    chk8(q, 8'h5A);
    $display("first_write done");
  endtask

  task automatic t_rw;
    logic [14:0] a [5] = '{15'h0000, 15'h0001, 15'h3FFF, 15'h4000, 15'h7FF7};
    logic [7:0]  q;
    for (int i = 0; i < 5; i++)
      wr(a[i], {i[3:0] + 4'h1, i[3:0] + 4'h1});
    for (int i = 0; i < 5; i++) begin
      rd(a[i], q);
      chk8(q, {i[3:0] + 4'h1, i[3:0] + 4'h1});
    end
    $display("rw done");
  endtask

  task automatic t_pins;
    logic [7:0] q;
    u_host.bus(3'h3, 1'h0, 15'h0001, 8'h00, 3, q);
    chk1(data_lines_oe, 1'h0);
    u_host.bus(3'h1, 1'h0, 15'h0001, 8'h00, 3, q);
    chk8(q, 8'h22);
    u_host.bus(3'h1, 1'h0, 15'h0003, 8'h00, 1, q);
    chk8(q, 8'h22);
    u_host.bus(3'h0, 1'h1, 15'h0001, 8'h22, 1, q);
    chk1(data_lines_oe, 1'h0);
    u_host.bus(3'h0, 1'h1, 15'h0001, 8'h22, 1, q);
    u_host.bus(3'h7, 1'h1, 15'h0001, 8'h22, 1, q);
    u_host.bus(3'h0, 1'h1, 15'h0002, 8'h66, 1, q);
    chk1(data_lines_oe, 1'h0);
    u_host.bus(3'h0, 1'h1, 15'h0002, 8'h66, 2, q);
    chk1(data_lines_oe, 1'h0);
    u_host.bus(3'h7, 1'h1, 15'h0002, 8'h66, 1, q);
    // select-controlled write; data changed after the earlier rise
    u_host.bus(3'h6, 1'h1, 15'h0003, 8'h77, 1, q);
    u_host.bus(3'h2, 1'h1, 15'h0003, 8'h77, 3, q);
    u_host.bus(3'h6, 1'h1, 15'h0003, 8'h77, 1, q);
    u_host.bus(3'h6, 1'h1, 15'h0003, 8'h88, 1, q);
    u_host.bus(3'h7, 1'h0, 15'h0003, 8'h00, 1, q);
    rd(15'h0003, q);
    chk8(q, 8'h77);
    rd(15'h0002, q);
    chk8(q, 8'h66);
    $display("pins done");
  endtask

  task automatic t_power;
    int         k;
    logic [7:0] q;
    wr(15'h0100, 8'h3C);
    @(posedge clk);
    #2;
    power_fail = 1'h1;
    wr(15'h0100, 8'hC3);
    u_host.bus(3'h1, 1'h0, 15'h0100, 8'h00, 3, q);
    chk1(data_lines_oe, 1'h0);
    chk1(write_protect, 1'h1);
    u_host.bus(3'h7, 1'h0, 15'h0100, 8'h00, 0, q);
    // supply returns on the usual drive offset after an edge
    @(posedge clk);
    #2;
    power_fail = 1'h0;
    await_ready(k);
    chk1(k >= REC - 2, 1'h1);
    rd(15'h0100, q);
    chk8(q, 8'h3C);
    $display("power done");
  endtask

  task automatic t_clock;
    logic [7:0] s0, s1, s2, s3, s4, q;
    rd(15'h7FF9, s0);
    repeat (TICK - 5) @(posedge clk);
    rd(15'h7FF9, s1);
    chk8(s1, inc(s0));
    rd(15'h7FFD, q);
    chk8(q, 8'h01);
    wr(15'h7FF8, 8'h40);
    rd(15'h7FF8, q);
    chk8(q, 8'h40);
    rd(15'h7FF9, s2);
    repeat (2 * TICK) @(posedge clk);
    rd(15'h7FF9, s3);
    chk8(s3, s2);
    wr(15'h7FF8, 8'h00);
    repeat (TICK) @(posedge clk);
    rd(15'h7FF9, s4);
    chk1(s4 !== s3 && s4 !== inc(s3), 1'h1);
    $display("clock done");
  endtask

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #2;
    rst = 1'h0;
    t_power_up;
    t_first_write;
    t_rw;
    t_pins;
    t_power;
    t_clock;
    finish_test;
  end

  // whole run needs well under this many edges
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
endmodule
